//--- tgmrb_counter.sv
// one wrapping statistic counter with synchronous clear
// assumes inc and clr are single-cycle pulses on mclk
`default_nettype none
`include "tgmrb_map.svh"
module tgmrb_counter #(
  parameter int WIDTH = `TGMRB_CNT_W
) (
  input wire logic mclk, // core clock
  input wire logic rst, // async reset, high
  input wire logic clr, // zero the count
  input wire logic inc, // count one frame
  output logic [WIDTH-1:0] count // current count
);
  import tgmrb_pkg::*;

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // a frame ending in the clear cycle still counts
  always_comb begin
    if (clr) begin
      cnt_d = WIDTH'(inc);
    end else begin
      cnt_d = cnt_q + WIDTH'(inc);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
endmodule
`default_nettype wire

//--- tgmrb_map.svh
// register offsets, field positions and reset values of the general register bank
// assumes byte addressing with one aligned 32-bit word per register
`ifndef TGMRB_MAP_SVH
`define TGMRB_MAP_SVH

`define TGMRB_ADDR_W 16
`define TGMRB_DATA_W 32
`define TGMRB_CNT_W 32
`define TGMRB_CNT_NUM 4

`define TGMRB_OFF_CONTROL 16'h0000
`define TGMRB_OFF_STATUS 16'h0004
`define TGMRB_OFF_VERSION 16'h000c
`define TGMRB_OFF_CNT_CTRL 16'h0040
`define TGMRB_OFF_RX_FRM 16'h0060
`define TGMRB_OFF_RX_ERR 16'h0064
`define TGMRB_OFF_TX_FRM 16'h0070
`define TGMRB_OFF_TX_ERR 16'h0074
`define TGMRB_OFF_MODE_COMMIT 16'h0080
`define TGMRB_OFF_MODE 16'h0084
`define TGMRB_OFF_ADDR_COMMIT 16'h0100
`define TGMRB_OFF_ADDR_LO 16'h0104
`define TGMRB_OFF_ADDR_HI 16'h0108

`define TGMRB_BIT_ENABLE 0
`define TGMRB_BIT_STROBE 0
`define TGMRB_CAP_HI 31
`define TGMRB_CAP_LO 24
`define TGMRB_QCNT_HI 19
`define TGMRB_QCNT_LO 16
`define TGMRB_BIT_LINK 10
`define TGMRB_BIT_SPLIT 4
`define TGMRB_BIT_ACCEPT_ALL 16
`define TGMRB_BIT_EARLY_FWD 20
`define TGMRB_VER_MAJ_HI 31
`define TGMRB_VER_MAJ_LO 24
`define TGMRB_VER_MIN_HI 23
`define TGMRB_VER_MIN_LO 16
`define TGMRB_VER_BLD_HI 15
`define TGMRB_VER_BLD_LO 0
`define TGMRB_ADDR_HI_W 16

`define TGMRB_IDX_RX_FRM 0
`define TGMRB_IDX_RX_ERR 1
`define TGMRB_IDX_TX_FRM 2
`define TGMRB_IDX_TX_ERR 3

`define TGMRB_RST_WORD 32'h0000_0000
`define TGMRB_RST_ADDR 48'h0000_0000_0000

`endif

//--- tgmrb_pkg.sv
// types shared by the general register bank and its counters
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package tgmrb_pkg;

  typedef struct packed {
    logic early_forward;
    logic accept_all;
  } tgmrb_mode_t;

  typedef struct packed {
    logic rx_done;
    logic rx_bad;
    logic tx_done;
    logic tx_bad;
  } tgmrb_frame_ev_t;

endpackage
`default_nettype wire

//--- tgmrb_regs.sv
// general configuration and status register bank of a time-sensitive networking node
// assumes a simple synchronous register port: one-cycle rd/wr strobes, byte addresses
// Behaviour
// - global enable in control bit zero
// - status shows eight build capability flags
// - single-window scheduler capability flag at bit 30
// - status bits 19:16 give queue count
// - status bit 4 shows frame splitting active
// - version word major, minor, build fields
// - counters exist only with statistics option
// - counter clear bit zeroes all, self-clears
// - counter of all received frames
// - counter of erroneous received frames
// - counter of all transmitted frames
// - counter of erroneous transmitted frames
// - mode commit applies mode, self-clears
// - accept-all bit forwards everything unfiltered
// - early-forward bit selects cut-through
// - address commit loads address, self-clears
// - station address six bytes, byte zero lowest
`default_nettype none
`include "tgmrb_map.svh"
module tgmrb_regs #(
  parameter logic [7:0] CAP_FLAGS = 8'hff, // build options, bit 7 early forward .. bit 0 queueing
  parameter logic [3:0] QUEUE_COUNT = 4'h3, // priority queues built
  parameter bit STATS_EN = 1'b1, // statistics_build_option
  parameter logic [7:0] VER_MAJOR = 8'h01, // arbitrary value
  parameter logic [7:0] VER_MINOR = 8'h00, // arbitrary value
  parameter logic [15:0] VER_BUILD = 16'h0000 // arbitrary value
) (
  input wire logic mclk, // core clock
  input wire logic rst, // async reset, high
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [`TGMRB_ADDR_W-1:0] reg_addr, // byte address
  input wire logic [`TGMRB_DATA_W-1:0] reg_wdata, // write data
  output logic [`TGMRB_DATA_W-1:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid pulse
  input wire logic link_up, // port link state
  input wire logic split_forced, // splitting forced by configuration
  input wire logic split_verified, // splitting negotiated by verification
  input wire tgmrb_pkg::tgmrb_frame_ev_t frame_ev, // frame end pulses
  output logic core_enable, // global enable
  output tgmrb_pkg::tgmrb_mode_t active_mode, // applied forwarding mode
  output logic mode_applied, // pulse when a mode is applied
  output logic [47:0] station_addr, // applied station address
  output logic station_addr_valid, // station address loaded
  output logic addr_applied // pulse when an address is applied
);
  import tgmrb_pkg::*;

  logic wr_control;
  logic wr_cnt_ctrl;
  logic wr_mode_commit;
  logic wr_mode;
  logic wr_addr_commit;
  logic wr_addr_lo;
  logic wr_addr_hi;

  assign wr_control = reg_wr && (reg_addr == `TGMRB_OFF_CONTROL);
  assign wr_cnt_ctrl = reg_wr && (reg_addr == `TGMRB_OFF_CNT_CTRL);
  assign wr_mode_commit = reg_wr && (reg_addr == `TGMRB_OFF_MODE_COMMIT);
  assign wr_mode = reg_wr && (reg_addr == `TGMRB_OFF_MODE);
  assign wr_addr_commit = reg_wr && (reg_addr == `TGMRB_OFF_ADDR_COMMIT);
  assign wr_addr_lo = reg_wr && (reg_addr == `TGMRB_OFF_ADDR_LO);
  assign wr_addr_hi = reg_wr && (reg_addr == `TGMRB_OFF_ADDR_HI);

  // control and mode group
  logic enable_q, enable_d;
  tgmrb_mode_t mode_shadow_q, mode_shadow_d;
  tgmrb_mode_t mode_active_q, mode_active_d;
  logic mode_commit_q, mode_commit_d;
  logic mode_applied_q, mode_applied_d;

  // the core is expected to be disabled while software changes these
  always_comb begin
    enable_d = enable_q;
    mode_shadow_d = mode_shadow_q;
    mode_active_d = mode_active_q;
    mode_applied_d = 1'b0;
    if (wr_control) begin
      enable_d = reg_wdata[`TGMRB_BIT_ENABLE];
    end
    if (wr_mode) begin
      mode_shadow_d.accept_all = reg_wdata[`TGMRB_BIT_ACCEPT_ALL];
      mode_shadow_d.early_forward = reg_wdata[`TGMRB_BIT_EARLY_FWD];
    end
    if (mode_commit_q) begin
      mode_active_d = mode_shadow_q;
      mode_applied_d = 1'b1;
    end
    // a new commit write in the clearing cycle wins over the self-clear
    mode_commit_d = wr_mode_commit ? reg_wdata[`TGMRB_BIT_STROBE] : 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
      mode_shadow_q <= '0;
      mode_active_q <= '0;
      mode_commit_q <= 1'b0;
      mode_applied_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      mode_shadow_q <= mode_shadow_d;
      mode_active_q <= mode_active_d;
      mode_commit_q <= mode_commit_d;
      mode_applied_q <= mode_applied_d;
    end
  end

  // station address group
  logic [`TGMRB_DATA_W-1:0] addr_lo_q, addr_lo_d;
  logic [`TGMRB_ADDR_HI_W-1:0] addr_hi_q, addr_hi_d;
  logic [47:0] addr_active_q, addr_active_d;
  logic addr_commit_q, addr_commit_d;
  logic addr_valid_q, addr_valid_d;
  logic addr_applied_q, addr_applied_d;

  always_comb begin
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    addr_active_d = addr_active_q;
    addr_valid_d = addr_valid_q;
    addr_applied_d = 1'b0;
    if (wr_addr_lo) begin
      addr_lo_d = reg_wdata;
    end
    if (wr_addr_hi) begin
      addr_hi_d = reg_wdata[`TGMRB_ADDR_HI_W-1:0];
    end
    if (addr_commit_q) begin
      // byte 0 sits in the low bits and leaves first on the wire
      addr_active_d = {addr_hi_q, addr_lo_q};
      addr_valid_d = 1'b1;
      addr_applied_d = 1'b1;
    end
    addr_commit_d = wr_addr_commit ? reg_wdata[`TGMRB_BIT_STROBE] : 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_lo_q <= `TGMRB_RST_WORD;
      addr_hi_q <= '0;
      addr_active_q <= `TGMRB_RST_ADDR;
      addr_commit_q <= 1'b0;
      addr_valid_q <= 1'b0;
      addr_applied_q <= 1'b0;
    end else begin
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      addr_active_q <= addr_active_d;
      addr_commit_q <= addr_commit_d;
      addr_valid_q <= addr_valid_d;
      addr_applied_q <= addr_applied_d;
    end
  end

  // statistics group
  logic cnt_clr_q, cnt_clr_d;
  logic [`TGMRB_CNT_NUM-1:0] cnt_inc;
  logic [`TGMRB_CNT_W-1:0] cnt [`TGMRB_CNT_NUM];

  always_comb begin
    cnt_clr_d = (STATS_EN && wr_cnt_ctrl) ? reg_wdata[`TGMRB_BIT_STROBE] : 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_clr_q <= 1'b0;
    end else begin
      cnt_clr_q <= cnt_clr_d;
    end
  end

  assign cnt_inc[`TGMRB_IDX_RX_FRM] = frame_ev.rx_done;
  assign cnt_inc[`TGMRB_IDX_RX_ERR] = frame_ev.rx_done && frame_ev.rx_bad;
  assign cnt_inc[`TGMRB_IDX_TX_FRM] = frame_ev.tx_done;
  assign cnt_inc[`TGMRB_IDX_TX_ERR] = frame_ev.tx_done && frame_ev.tx_bad;

  for (genvar i = 0; i < `TGMRB_CNT_NUM; i++) begin : g_cnt
    if (STATS_EN) begin : g_on
      tgmrb_counter #(.WIDTH(`TGMRB_CNT_W)) u_cnt (
        .mclk(mclk),
        .rst(rst),
        .clr(cnt_clr_q),
        .inc(cnt_inc[i]),
        .count(cnt[i])
      );
    end else begin : g_off
      assign cnt[i] = '0;
    end
  end

  // read path
  logic [`TGMRB_DATA_W-1:0] status_word;
  logic [`TGMRB_DATA_W-1:0] rd_word;
  logic [`TGMRB_DATA_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  always_comb begin
    status_word = '0;
    status_word[`TGMRB_CAP_HI:`TGMRB_CAP_LO] = CAP_FLAGS;
    status_word[`TGMRB_QCNT_HI:`TGMRB_QCNT_LO] = QUEUE_COUNT;
    status_word[`TGMRB_BIT_LINK] = link_up;
    status_word[`TGMRB_BIT_SPLIT] = split_forced || split_verified;
  end

  // unmapped addresses and reserved bits read zero
  always_comb begin
    rd_word = '0;
    if (reg_addr == `TGMRB_OFF_CONTROL) begin
      rd_word[`TGMRB_BIT_ENABLE] = enable_q;
    end else if (reg_addr == `TGMRB_OFF_STATUS) begin
      rd_word = status_word;
    end else if (reg_addr == `TGMRB_OFF_VERSION) begin
      rd_word = {VER_MAJOR, VER_MINOR, VER_BUILD};
    end else if (reg_addr == `TGMRB_OFF_CNT_CTRL) begin
      rd_word[`TGMRB_BIT_STROBE] = cnt_clr_q;
    end else if (reg_addr == `TGMRB_OFF_RX_FRM) begin
      rd_word = cnt[`TGMRB_IDX_RX_FRM];
    end else if (reg_addr == `TGMRB_OFF_RX_ERR) begin
      rd_word = cnt[`TGMRB_IDX_RX_ERR];
    end else if (reg_addr == `TGMRB_OFF_TX_FRM) begin
      rd_word = cnt[`TGMRB_IDX_TX_FRM];
    end else if (reg_addr == `TGMRB_OFF_TX_ERR) begin
      rd_word = cnt[`TGMRB_IDX_TX_ERR];
    end else if (reg_addr == `TGMRB_OFF_MODE_COMMIT) begin
      rd_word[`TGMRB_BIT_STROBE] = mode_commit_q;
    end else if (reg_addr == `TGMRB_OFF_MODE) begin
      rd_word[`TGMRB_BIT_ACCEPT_ALL] = mode_shadow_q.accept_all;
      rd_word[`TGMRB_BIT_EARLY_FWD] = mode_shadow_q.early_forward;
    end else if (reg_addr == `TGMRB_OFF_ADDR_COMMIT) begin
      rd_word[`TGMRB_BIT_STROBE] = addr_commit_q;
    end else if (reg_addr == `TGMRB_OFF_ADDR_LO) begin
      rd_word = addr_lo_q;
    end else if (reg_addr == `TGMRB_OFF_ADDR_HI) begin
      rd_word[`TGMRB_ADDR_HI_W-1:0] = addr_hi_q;
    end
  end

  always_comb begin
    rdata_d = reg_rd ? rd_word : rdata_q;
    rvalid_d = reg_rd;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= `TGMRB_RST_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign core_enable = enable_q;
  assign active_mode = mode_active_q;
  assign mode_applied = mode_applied_q;
  assign station_addr = addr_active_q;
  assign station_addr_valid = addr_valid_q;
  assign addr_applied = addr_applied_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [`TGMRB_ADDR_W-1:0] a);
    reg_rd && (reg_addr == a);
  endsequence

  sequence s_mode_commit;
    wr_mode_commit && reg_wdata[`TGMRB_BIT_STROBE];
  endsequence

  sequence s_addr_commit;
    wr_addr_commit && reg_wdata[`TGMRB_BIT_STROBE];
  endsequence

  property p_enable_read;
    s_rd(`TGMRB_OFF_CONTROL) |=> reg_rvalid && (reg_rdata == {31'h0, $past(core_enable)});
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("control readback wrong");

  property p_enable_write;
    wr_control |=> core_enable == $past(reg_wdata[`TGMRB_BIT_ENABLE]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not taken");

  property p_status_caps;
    s_rd(`TGMRB_OFF_STATUS) |=> reg_rdata[`TGMRB_CAP_HI:`TGMRB_CAP_LO] == CAP_FLAGS
      && reg_rdata[`TGMRB_QCNT_HI:`TGMRB_QCNT_LO] == QUEUE_COUNT;
  endproperty
  a_status_caps: assert property (p_status_caps) else $error("capability fields wrong");

  property p_status_live;
    s_rd(`TGMRB_OFF_STATUS) |=> reg_rdata[`TGMRB_BIT_LINK] == $past(link_up)
      && reg_rdata[`TGMRB_BIT_SPLIT] == $past(split_forced || split_verified)
      && reg_rdata[23:20] == 4'h0 && reg_rdata[15:11] == 5'h00 && reg_rdata[9:5] == 5'h00;
  endproperty
  a_status_live: assert property (p_status_live) else $error("link or split bit wrong");

  property p_version;
    s_rd(`TGMRB_OFF_VERSION) |=> reg_rdata[31:24] == VER_MAJOR && reg_rdata[23:16] == VER_MINOR
      && reg_rdata[15:0] == VER_BUILD;
  endproperty
  a_version: assert property (p_version) else $error("version word wrong");

  property p_mode_apply;
    s_mode_commit ##1 !wr_mode_commit |=> mode_applied && !mode_commit_q
      && active_mode == $past(mode_shadow_q);
  endproperty
  a_mode_apply: assert property (p_mode_apply) else $error("mode not applied or not cleared");

  property p_mode_hold;
    !mode_commit_q |=> $stable(active_mode) && !mode_applied;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without commit");

  property p_addr_apply;
    s_addr_commit ##1 !wr_addr_commit |=> addr_applied && station_addr_valid && !addr_commit_q
      && station_addr[7:0] == $past(addr_lo_q[7:0]) && station_addr[47:40] == $past(addr_hi_q[15:8]);
  endproperty
  a_addr_apply: assert property (p_addr_apply) else $error("address not applied");

  property p_counter_clear;
    STATS_EN && wr_cnt_ctrl && reg_wdata[`TGMRB_BIT_STROBE] |=> ##1 cnt[`TGMRB_IDX_RX_FRM] <= 32'h1
      && cnt[`TGMRB_IDX_RX_ERR] <= 32'h1 && cnt[`TGMRB_IDX_TX_FRM] <= 32'h1 && cnt[`TGMRB_IDX_TX_ERR] <= 32'h1;
  endproperty
  a_counter_clear: assert property (p_counter_clear) else $error("counters not cleared");

  property p_rx_count;
    STATS_EN && !cnt_clr_q |=> cnt[`TGMRB_IDX_RX_FRM] == 32'($past(cnt[`TGMRB_IDX_RX_FRM]) + 32'($past(frame_ev.rx_done)));
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("receive count step wrong");

  property p_tx_err_only;
    STATS_EN && !cnt_clr_q && !(frame_ev.tx_done && frame_ev.tx_bad) |=> $stable(cnt[`TGMRB_IDX_TX_ERR]);
  endproperty
  a_tx_err_only: assert property (p_tx_err_only) else $error("transmit error count moved");

  property p_unmapped;
    reg_rd && (reg_addr == 16'h0008) |=> reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
`default_nettype wire

//--- tgmrb_regs_bench.sv
// self-checking bench for the general register bank: register port, counters, commit strobes
// assumes the strobe register port with a fixed one-cycle read answer and 100 MHz mclk
`default_nettype none
`include "tgmrb_map.svh"
module tgmrb_regs_bench import tgmrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CAP = 8'h5a; // uneven pattern exposes flag order
  localparam logic [3:0] QC = 4'h6;
  logic mclk, rst, reg_wr, reg_rd, link_up, split_forced, split_verified;
  logic [`TGMRB_ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ns_rdata;
  logic reg_rvalid, core_enable, mode_applied, station_addr_valid, addr_applied;
  logic [47:0] station_addr;
  tgmrb_frame_ev_t frame_ev;
  tgmrb_mode_t active_mode;
  int num_errors, n_checks;

  tgmrb_regs #(.CAP_FLAGS(CAP), .QUEUE_COUNT(QC), .STATS_EN(1'b1), .VER_MAJOR(8'h12), .VER_MINOR(8'h34),
    .VER_BUILD(16'h5678)) i_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_up(link_up),
    .split_forced(split_forced), .split_verified(split_verified), .frame_ev(frame_ev), .core_enable(core_enable),
    .active_mode(active_mode), .mode_applied(mode_applied), .station_addr(station_addr),
    .station_addr_valid(station_addr_valid), .addr_applied(addr_applied));
  // second build without statistics, fed the same stimulus
  tgmrb_regs #(.STATS_EN(1'b0)) i_dut_nostats (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(ns_rdata), .reg_rvalid(), .link_up(link_up),
    .split_forced(split_forced), .split_verified(split_verified), .frame_ev(frame_ev), .core_enable(),
    .active_mode(), .mode_applied(), .station_addr(), .station_addr_valid(), .addr_applied());

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(48'(reg_rvalid), 48'h1);
    chk(48'(reg_rdata), 48'(exp));
  endtask

  // write then read the same place in the very next cycle, to catch a one-cycle strobe bit
  task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(48'(reg_rdata), 48'(exp));
  endtask

  function automatic logic [31:0] stat(input logic [7:0] c, input logic [3:0] q, input logic l, input logic s);
    return {c, 4'h0, q, 5'h0, l, 5'h0, s, 4'h0};
  endfunction

  initial begin
    #500us;
    num_errors++;
    conclude();
  end

  initial begin
    logic [15:0] zero_a[10];
    logic [15:0] cnt_a[4];
    logic [3:0] evs[7];
    int cexp[4];
    logic [2:0] k;
    logic [1:0] m;
    logic [1:0] prev;
    logic [31:0] mw;
    zero_a = '{`TGMRB_OFF_CONTROL, `TGMRB_OFF_CNT_CTRL, `TGMRB_OFF_RX_FRM, `TGMRB_OFF_RX_ERR, `TGMRB_OFF_TX_FRM,
      `TGMRB_OFF_TX_ERR, `TGMRB_OFF_MODE_COMMIT, `TGMRB_OFF_MODE, `TGMRB_OFF_ADDR_LO, `TGMRB_OFF_ADDR_HI};
    cnt_a = '{`TGMRB_OFF_RX_FRM, `TGMRB_OFF_RX_ERR, `TGMRB_OFF_TX_FRM, `TGMRB_OFF_TX_ERR};
    // back-to-back frame ends, a bad flag without a done, and rx and tx together
    evs = '{4'b1000, 4'b1100, 4'b0100, 4'b0010, 4'b0011, 4'b0001, 4'b1010};
    cexp = '{0, 0, 0, 0};
    prev = 2'b00;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    link_up = 1'b0;
    split_forced = 1'b0;
    split_verified = 1'b0;
    frame_ev = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd_chk(zero_a[i], 32'h0);
    chk(48'({core_enable, active_mode, station_addr_valid}), 48'h0);
    chk(station_addr, 48'h0);
    rd_chk(`TGMRB_OFF_VERSION, 32'h1234_5678);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      @(posedge mclk);
      link_up <= k[2];
      split_forced <= k[1];
      split_verified <= k[0];
      rd_chk(`TGMRB_OFF_STATUS, stat(CAP, QC, k[2], k[1] | k[0]));
      chk(48'(ns_rdata), 48'(stat(8'hff, 4'h3, k[2], k[1] | k[0])));
    end
    // read-only and unmapped places ignore writes
    wr(`TGMRB_OFF_STATUS, 32'hffff_ffff);
    wr(`TGMRB_OFF_VERSION, 32'h0);
    wr(16'h0008, 32'hffff_ffff);
    rd_chk(`TGMRB_OFF_STATUS, stat(CAP, QC, 1'b1, 1'b1));
    rd_chk(`TGMRB_OFF_VERSION, 32'h1234_5678);
    rd_chk(16'h0008, 32'h0);
    rd_chk(16'h0102, 32'h0);
    wr(`TGMRB_OFF_CONTROL, 32'hffff_ffff);
    rd_chk(`TGMRB_OFF_CONTROL, 32'h1);
    chk(48'(core_enable), 48'h1);
    wr(`TGMRB_OFF_CONTROL, 32'h0);
    rd_chk(`TGMRB_OFF_CONTROL, 32'h0);
    chk(48'(core_enable), 48'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      frame_ev <= tgmrb_frame_ev_t'(evs[i]);
      cexp[0] += int'(evs[i][3]);
      cexp[1] += int'(evs[i][3] & evs[i][2]);
      cexp[2] += int'(evs[i][1]);
      cexp[3] += int'(evs[i][1] & evs[i][0]);
    end
    @(posedge mclk);
    frame_ev <= '0;
    for (int i = 0; i < 4; i++) begin
      rd_chk(cnt_a[i], 32'(cexp[i]));
      chk(48'(ns_rdata), 48'h0);
    end
    wr_rd(`TGMRB_OFF_CNT_CTRL, 32'hffff_ffff, 32'h1);
    chk(48'(ns_rdata), 48'h0);
    for (int i = 0; i < 4; i++) rd_chk(cnt_a[i], 32'h0);
    rd_chk(`TGMRB_OFF_CNT_CTRL, 32'h0);
    // every mode combination; reserved bits written as ones must read back zero
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      mw = {11'h0, m[1], 3'h0, m[0], 16'h0};
      wr(`TGMRB_OFF_MODE, 32'hffee_ffff | mw);
      rd_chk(`TGMRB_OFF_MODE, mw);
      chk(48'(active_mode), 48'(prev));
      wr_rd(`TGMRB_OFF_MODE_COMMIT, 32'hffff_ffff, 32'h1);
      chk(48'(mode_applied), 48'h1);
      chk(48'(active_mode), 48'(m));
      @(posedge mclk);
      #1;
      chk(48'(mode_applied), 48'h0);
      rd_chk(`TGMRB_OFF_MODE_COMMIT, 32'h0);
      prev = m;
    end
    wr(`TGMRB_OFF_ADDR_LO, 32'h0123_4567);
    wr(`TGMRB_OFF_ADDR_HI, 32'hffff_89ab);
    rd_chk(`TGMRB_OFF_ADDR_HI, 32'h0000_89ab);
    chk(48'(station_addr_valid), 48'h0);
    wr_rd(`TGMRB_OFF_ADDR_COMMIT, 32'hffff_ffff, 32'h1);
    chk(48'(addr_applied), 48'h1);
    chk(48'(station_addr_valid), 48'h1);
    chk(station_addr, 48'h89ab_0123_4567);
    wr(`TGMRB_OFF_ADDR_LO, 32'h89ab_cdef);
    rd_chk(`TGMRB_OFF_ADDR_LO, 32'h89ab_cdef);
    rd_chk(`TGMRB_OFF_ADDR_COMMIT, 32'h0);
    chk(station_addr, 48'h89ab_0123_4567);
    // configuration done with the core off, switch the core back on
    wr(`TGMRB_OFF_CONTROL, 32'h1);
    #1;
    chk(48'(core_enable), 48'h1);
    conclude();
  end
endmodule
`default_nettype wire
